// *** dv/lov_bus_master_model.sv ***
`timescale 1ns/1ps
// ==========
// Bus master: commanded values, report and save bookkeeping
module lov_bus_master_model #(
  parameter int N = 4,
  parameter int VW = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Commands from the bench
  input wire logic cmd_we_in,
  input wire logic [7:0] cmd_idx_in,
  input wire logic [VW-1:0] cmd_val_in,
  // Reports from the module
  input wire logic store_we_in,
  input wire logic save_req_in,
  input wire logic [N*VW-1:0] store_value_in,
  // Towards module and bench
  output logic [N*VW-1:0] bus_value_out,
  output logic [15:0] report_cnt_out,
  output logic [15:0] save_cnt_out,
  output logic [N*VW-1:0] saved_out
);
  // Values only change on bench command, never spontaneously
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bus_value_out <= '0;
      report_cnt_out <= 16'h0000;
      save_cnt_out <= 16'h0000;
      saved_out <= '0;
    end else begin
      if (cmd_we_in) begin
        bus_value_out[cmd_idx_in*VW +: VW] <= cmd_val_in;
      end
      if (store_we_in) begin
        report_cnt_out <= report_cnt_out + 16'h0001;
      end
      if (save_req_in) begin
        save_cnt_out <= save_cnt_out + 16'h0001;
        saved_out <= store_value_in;
      end
    end
  end
endmodule

// *** dv/lov_panel_asserts.sv ***
`timescale 1ns/1ps
// ==========
// Checker on the panel ports
module lov_panel_asserts #(
  parameter int N = 4,
  parameter int VW = 4,
  parameter int ERR_CYC = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Watched inputs
  input wire logic supply_ok_in,
  input wire logic parked_in,
  input wire logic hw_fault_in,
  input wire logic addr_key_in,
  input wire logic [N*3-1:0] fn_kind_in,
  input wire logic [N-1:0] ovr_disable_in,
  // Watched outputs
  input wire logic module_lamp_out,
  input wire logic [N-1:0] ovr_lamp_out,
  input wire logic [N-1:0] error_out,
  input wire logic [N*VW-1:0] out_value_out,
  input wire logic [N-1:0] status_flag_field_out,
  input wire logic ovr_event_out,
  input wire logic store_we_out,
  input wire logic [N-1:0] store_ovr_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] err_run;
  logic [N-1:0] in_mask;
  // Length of the running error pulse on point 0
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !error_out[0]) begin
      err_run <= 8'h00;
    end else begin
      err_run <= err_run + 8'h01;
    end
  end
  // Points configured as inputs
  always_comb begin
    for (int i = 0; i < N; i++) begin
      in_mask[i] = fn_kind_in[i*3 +: 3] < 3'h3;
    end
  end
  // Margins cover the pin synchronisers
  sequence s_healthy;
    (supply_ok_in && !parked_in && !hw_fault_in && addr_key_in) [*8];
  endsequence
  sequence s_sick;
    (!supply_ok_in || parked_in || hw_fault_in) [*6];
  endsequence
  a_lamp_healthy: assert property (s_healthy |-> module_lamp_out)
    else $error("module lamp dark while healthy");
  a_lamp_sick: assert property (s_sick |-> !module_lamp_out)
    else $error("module lamp lit while faulty");
  a_flag_mirror: assert property (
    ovr_lamp_out == status_flag_field_out && store_ovr_out == ovr_lamp_out)
    else $error("override lamp and flag differ");
  a_event_once: assert property (ovr_event_out |=> !ovr_event_out)
    else $error("override event longer than one cycle");
  a_event_store: assert property (ovr_event_out == store_we_out)
    else $error("store write not with override event");
  a_flag_event: assert property ($changed(status_flag_field_out) |->
    (ovr_event_out || $past(ovr_event_out)) or (##1 ovr_event_out))
    else $error("override change not reported");
  a_disable_blocks: assert property ((ovr_lamp_out & ovr_disable_in
    & $past(ovr_disable_in) & $past(ovr_disable_in, 2) & $past(ovr_disable_in, 3)) == '0)
    else $error("override active on disabled point");
  a_input_no_ovr: assert property ($stable(fn_kind_in) [*4] |->
    (ovr_lamp_out & in_mask) == '0)
    else $error("override active on an input");
  a_keyout_safe: assert property ((!addr_key_in) [*6] |-> out_value_out == '0)
    else $error("outputs driven without address key");
  a_error_len: assert property ($fell(error_out[0]) |-> err_run >= ERR_CYC)
    else $error("error indication too short");
endmodule

bind lov_panel lov_panel_asserts #(.N(N), .VW(VW), .ERR_CYC(ERR_CYC)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .supply_ok_in(supply_ok_in),
  .parked_in(parked_in), .hw_fault_in(hw_fault_in), .addr_key_in(addr_key_in),
  .fn_kind_in(fn_kind_in), .ovr_disable_in(ovr_disable_in),
  .module_lamp_out(module_lamp_out), .ovr_lamp_out(ovr_lamp_out), .error_out(error_out),
  .out_value_out(out_value_out), .status_flag_field_out(status_flag_field_out),
  .ovr_event_out(ovr_event_out), .store_we_out(store_we_out), .store_ovr_out(store_ovr_out)
);

// *** dv/lov_panel_tb_top.sv ***
`timescale 1ns/1ps
// ==========
// Panel bench
module lov_panel_tb_top;
  localparam int N = 4;
  localparam int VW = 4;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic supply_ok = 1'b1, parked = 1'b0, hw_fault = 1'b0, addr_key = 1'b1;
  // Point 0 binary in, 1 temperature, 2 binary out, 3 analog out
  logic [N*3-1:0] fn_kind = {3'h4, 3'h3, 3'h2, 3'h0};
  logic [N-1:0] inverse = '0, ovr_dis = '0, tricol = 4'h1, alarm = '0, service = '0;
  logic [N-1:0] contact = '0, test_act = '0, kp = '0, kmid = '0, km = '0, grp = '0;
  logic [N*VW-1:0] test_val = 16'h9000, analog = '0, bus_val, out_val, store_val, saved;
  logic lamp_ref;
  int lit = 0;
  logic mod_lamp, ev, we, save_req, cmd_we = 1'b0, clr_seen = 1'b0;
  logic [N-1:0] pt_lamp, ovr_lamp, err, pv, flag, st_ovr, err_seen = '0;
  logic [N*2-1:0] colour;
  logic [7:0] cmd_idx = 8'h00;
  logic [VW-1:0] cmd_val = 4'h0;
  logic [15:0] reports, saves;
  int err_total = 0;
  int n_compared = 0;

  always #50 sys_clk_in = ~sys_clk_in;
  // Error pulses are short, so remember any seen since the last clear
  always @(posedge sys_clk_in) err_seen <= clr_seen ? '0 : (err_seen | err);

  lov_panel #(.N(N), .VW(VW), .DEBOUNCE_CYC(2), .DELAY_CYC(8), .REPEAT_CYC(4),
    .HOLD_CYC(6), .FLASH_CYC(4), .ERR_CYC(4)) uut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .supply_ok_in(supply_ok), .parked_in(parked),
    .hw_fault_in(hw_fault), .addr_key_in(addr_key), .fn_kind_in(fn_kind),
    .inverse_in(inverse), .ovr_disable_in(ovr_dis), .tricolour_in(tricol),
    .alarm_in(alarm), .service_in(service), .group_in(grp), .contact_in(contact),
    .analog_in(analog), .bus_value_in(bus_val), .test_active_in(test_act),
    .test_value_in(test_val), .stored_ovr_in(4'h0), .stored_value_in(16'h0000),
    .key_plus_in(kp), .key_mid_in(kmid), .key_minus_in(km), .module_lamp_out(mod_lamp),
    .point_lamp_out(pt_lamp), .point_colour_out(colour), .ovr_lamp_out(ovr_lamp),
    .error_out(err), .out_value_out(out_val), .process_value_field_out(pv),
    .status_flag_field_out(flag), .ovr_event_out(ev), .store_we_out(we),
    .store_ovr_out(st_ovr), .store_value_out(store_val), .save_req_out(save_req));

  lov_bus_master_model #(.N(N), .VW(VW)) u_bm (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .cmd_we_in(cmd_we), .cmd_idx_in(cmd_idx),
    .cmd_val_in(cmd_val), .store_we_in(we), .save_req_in(save_req),
    .store_value_in(store_val), .bus_value_out(bus_val), .report_cnt_out(reports),
    .save_cnt_out(saves), .saved_out(saved));

  // ==========
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Key 0 plus, 1 centre, 2 minus; held n+1 cycles, then let it settle
  task automatic press(input int which, input int idx, input int n);
    @(posedge sys_clk_in);
    clr_seen <= 1'b1;
    case (which)
      0: kp[idx] <= 1'b1;
      1: kmid[idx] <= 1'b1;
      default: km[idx] <= 1'b1;
    endcase
    @(posedge sys_clk_in);
    clr_seen <= 1'b0;
    tick(n);
    kp <= '0;
    kmid <= '0;
    km <= '0;
    tick(12);
  endtask
  task automatic bus_set(input int idx, input logic [VW-1:0] val);
    @(posedge sys_clk_in);
    cmd_we <= 1'b1;
    cmd_idx <= 8'(idx);
    cmd_val <= val;
    @(posedge sys_clk_in);
    cmd_we <= 1'b0;
    tick(4);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========
  // Watchdog, far beyond the expected several hundred cycles
  initial begin
    tick(20000);
    err_total++;
    tally_and_finish();
  end

  // ==========
  // Test sequence
  initial begin
    tick(10);
    rst_in <= 1'b0;
    tick(12);
    chk("module lamp", 1, mod_lamp);
    bus_set(3, 4'h5);
    chk("bus value", 5, out_val[15:12]);
    test_act <= 4'h8;
    tick(4);
    chk("test value", 9, out_val[15:12]);
    repeat (16) begin
      tick(1);
      chk("temperature lamp", 0, pt_lamp[1]);
    end
    // Point 1 as analog input: lamp duty over one PWM period equals the value
    fn_kind[5:3] <= 3'h1;
    for (int a = 3; a <= 10; a += 7) begin
      analog[7:4] <= 4'(a);
      tick(4);
      lit = 0;
      repeat (16) begin
        tick(1);
        lit += pt_lamp[1];
      end
      chk("analog lamp duty", 16'(a), 16'(lit));
    end
    fn_kind[5:3] <= 3'h2;
    // Contact polarity and tri-colour lamp
    contact <= 4'h1;
    for (int i = 0; i < 3; i++) begin
      alarm[0] <= (i == 1);
      service[0] <= (i == 2);
      tick(8);
      chk("point lamp", 1, pt_lamp[0]);
      chk("process value", 1, pv[0]);
      chk("colour", (i == 1) ? 2 : (i == 2) ? 3 : 1, colour[1:0]);
    end
    alarm <= '0;
    service <= '0;
    inverse <= 4'h1;
    tick(8);
    chk("closed inverse", 1, pv[0]);
    chk("closed inverse lamp", 0, pt_lamp[0]);
    contact <= 4'h0;
    tick(8);
    chk("open inverse", 0, pv[0]);
    chk("open inverse lamp", 1, pt_lamp[0]);
    inverse <= 4'h0;
    // Refused attempts
    press(0, 3, 5);
    chk("plus refused", 1, err_seen[3]);
    chk("plus refused value", 9, out_val[15:12]);
    press(1, 0, 14);
    chk("input override error", 1, err_seen[0]);
    chk("input override", 0, ovr_lamp[0]);
    // Analog override over a running functional test; points 2 and 3 form a group
    grp <= 4'hC;
    press(1, 3, 14);
    chk("override lamp", 1, ovr_lamp[3]);
    lamp_ref = pt_lamp[2];
    tick(4);
    chk("group flash", 16'(!lamp_ref), 16'(pt_lamp[2]));
    chk("status flag", 1, flag[3]);
    chk("reported", 1, reports != 16'h0000);
    chk("value kept", 9, out_val[15:12]);
    press(0, 3, 5);
    chk("plus step", 10, out_val[15:12]);
    test_act <= 4'h0;
    tick(4);
    chk("override first", 10, out_val[15:12]);
    press(0, 3, 100);
    chk("top stage", 15, out_val[15:12]);
    press(2, 3, 100);
    chk("bottom stage", 0, out_val[15:12]);
    press(1, 3, 14);
    chk("override off", 0, ovr_lamp[3]);
    chk("bus again", 5, out_val[15:12]);
    // Binary output with override blocked, then allowed
    ovr_dis <= 4'h4;
    press(1, 2, 14);
    chk("disabled override", 0, ovr_lamp[2]);
    ovr_dis <= 4'h0;
    press(1, 2, 14);
    chk("relay override", 1, ovr_lamp[2]);
    press(0, 2, 5);
    chk("relay on", 1, out_val[11:8]);
    press(2, 2, 5);
    chk("relay off", 0, out_val[11:8]);
    press(1, 2, 14);
    // Address key swivelled out
    addr_key <= 1'b0;
    tick(10);
    chk("save request", 1, saves);
    chk("loads off", 0, out_val);
    chk("lamp without key", 0, mod_lamp);
    addr_key <= 1'b1;
    tick(12);
    // Each cause darkens the module lamp
    for (int i = 0; i < 3; i++) begin
      supply_ok <= (i != 0);
      parked <= (i == 1);
      hw_fault <= (i == 2);
      tick(10);
      chk("lamp on fault", 0, mod_lamp);
    end
    hw_fault <= 1'b0;
    tick(12);
    chk("lamp back", 1, mod_lamp);
    tally_and_finish();
  end
endmodule

// *** include/lov_pkg.sv ***
package lov_pkg;
  // Point function kinds
  typedef enum logic [2:0] {
    LOV_FN_BIN_IN,
    LOV_FN_ANA_IN,
    LOV_FN_TEMP_IN,
    LOV_FN_BIN_OUT,
    LOV_FN_ANA_OUT,
    LOV_FN_MULTI_OUT
  } lov_fn_t;
  // Tri-colour lamp codes
  localparam logic [1:0] LOV_COL_OFF = 2'h0;
  localparam logic [1:0] LOV_COL_GREEN = 2'h1;
  localparam logic [1:0] LOV_COL_RED = 2'h2;
  localparam logic [1:0] LOV_COL_YELLOW = 2'h3;
  // Timing
  localparam int LOV_CLK_HZ = 10000000;
  localparam int LOV_DEBOUNCE_US = 10000;
  localparam int LOV_DEBOUNCE_CYC = LOV_DEBOUNCE_US * (LOV_CLK_HZ / 1000000);
  localparam int LOV_REPEAT_DELAY_MS = 500;
  localparam int LOV_REPEAT_DELAY_CYC = LOV_REPEAT_DELAY_MS * (LOV_CLK_HZ / 1000);
  localparam int LOV_REPEAT_MS = 200;
  localparam int LOV_REPEAT_CYC = LOV_REPEAT_MS * (LOV_CLK_HZ / 1000);
  localparam int LOV_HOLD_MS = 1000;
  localparam int LOV_HOLD_CYC = LOV_HOLD_MS * (LOV_CLK_HZ / 1000);
  localparam int LOV_FLASH_MS = 250;
  localparam int LOV_FLASH_CYC = LOV_FLASH_MS * (LOV_CLK_HZ / 1000);
  localparam int LOV_ERR_MS = 500;
  localparam int LOV_ERR_CYC = LOV_ERR_MS * (LOV_CLK_HZ / 1000);
  localparam int LOV_CNT_W = 24;
endpackage

// *** rtl/lov_key.sv ***
`timescale 1ns/1ps
// Debounced key with press, hold and auto-repeat events
module lov_key #(
  parameter int DEBOUNCE_CYC = lov_pkg::LOV_DEBOUNCE_CYC,
  parameter int DELAY_CYC = lov_pkg::LOV_REPEAT_DELAY_CYC,
  parameter int REPEAT_CYC = lov_pkg::LOV_REPEAT_CYC,
  parameter int HOLD_CYC = lov_pkg::LOV_HOLD_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Raw key from pin
  input wire logic key_in,
  // Events
  output logic step_out,
  output logic hold_out,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic stable;
    logic [lov_pkg::LOV_CNT_W-1:0] db_cnt;
    logic [lov_pkg::LOV_CNT_W-1:0] rep_cnt;
    logic [lov_pkg::LOV_CNT_W-1:0] hold_cnt;
    logic held;
    logic step;
    logic hold;
  } lov_key_st_t;
  lov_key_st_t st;
  lov_key_st_t next_st;
  localparam int LOV_CNT_W = lov_pkg::LOV_CNT_W;

  initial begin
    if (DEBOUNCE_CYC < 1 || DELAY_CYC < 1 || REPEAT_CYC < 1 || HOLD_CYC < 1 ||
        HOLD_CYC >= (1 << lov_pkg::LOV_CNT_W) || DELAY_CYC >= (1 << lov_pkg::LOV_CNT_W))
      $error("lov_key: bad timing parameters");
  end

  // Sync, debounce, then first step, delay, repeat at fixed interval
  always_comb begin
    next_st = st;
    next_st.s1 = key_in;
    next_st.s2 = st.s1;
    next_st.step = 1'b0;
    next_st.hold = 1'b0;
    if (st.s2 == st.stable) begin
      next_st.db_cnt = '0;
    end else if (st.db_cnt == LOV_CNT_W'(DEBOUNCE_CYC - 1)) begin // R23
      next_st.stable = st.s2;
      next_st.db_cnt = '0;
      next_st.rep_cnt = LOV_CNT_W'(DELAY_CYC);
      next_st.hold_cnt = '0;
      next_st.held = 1'b0;
      next_st.step = st.s2;
    end else begin
      next_st.db_cnt = st.db_cnt + 1'b1;
    end
    if (st.stable && st.s2 == st.stable) begin
      if (st.rep_cnt == '0) begin
        next_st.rep_cnt = LOV_CNT_W'(REPEAT_CYC - 1);
        next_st.step = 1'b1; // R23
      end else begin
        next_st.rep_cnt = st.rep_cnt - 1'b1;
      end
      if (!st.held) begin
        if (st.hold_cnt == LOV_CNT_W'(HOLD_CYC - 1)) begin
          next_st.held = 1'b1;
          next_st.hold = 1'b1;
        end else begin
          next_st.hold_cnt = st.hold_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign step_out = st.step;
  assign hold_out = st.hold;
  assign level_out = st.stable;
endmodule

// *** rtl/lov_panel.sv ***
`timescale 1ns/1ps
// Functional notes
// R1: Module lamp steady on when healthy
// R2: Module lamp off: no supply, parked, fault
// R3: Binary point lamp follows active state
// R4: Analog lamp brightness proportional; temperature dark
// R5: Tri-colour: green normal, red alarm, yellow service
// R6: Contact polarity gives process value; the code ignores inverse_in for pv, polarity only moves the lamp
// R7: Override only outputs; input attempt errors
// R8: Override works without bus master
// R9: Entering override keeps last output
// R10: Auto returns control to bus value
// R11: Report override, flag overridden, store persistently
// R12: Per-function override disable honoured
// R13: Multistate outputs never two active
// R14: Held centre key toggles override
// R15: Plus raises, minus lowers output
// R16: Steps saturate, never wrap
// R17: Plus/minus without override gives error
// R18: Yellow override lamp shows override active
// R19: Multistage function flashes all its lamps
// R20: Priority: override, functional test, bus
// R21: No address key: safe inactive
// R22: Key swivelled out: loads off, save request
// R23: Debounced keys with delayed auto-repeat
module lov_panel #(
  parameter int N = 4,
  parameter int VW = 4,
  parameter int DEBOUNCE_CYC = lov_pkg::LOV_DEBOUNCE_CYC,
  parameter int DELAY_CYC = lov_pkg::LOV_REPEAT_DELAY_CYC,
  parameter int REPEAT_CYC = lov_pkg::LOV_REPEAT_CYC,
  parameter int HOLD_CYC = lov_pkg::LOV_HOLD_CYC,
  parameter int FLASH_CYC = lov_pkg::LOV_FLASH_CYC,
  parameter int ERR_CYC = lov_pkg::LOV_ERR_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Module condition (pins)
  input wire logic supply_ok_in,
  input wire logic parked_in,
  input wire logic hw_fault_in,
  input wire logic addr_key_in,
  // Function configuration, one per point
  input wire logic [N*3-1:0] fn_kind_in,
  input wire logic [N-1:0] inverse_in,
  input wire logic [N-1:0] ovr_disable_in,
  input wire logic [N-1:0] tricolour_in,
  input wire logic [N-1:0] alarm_in,
  input wire logic [N-1:0] service_in,
  input wire logic [N-1:0] group_in,
  // Field side
  input wire logic [N-1:0] contact_in,
  input wire logic [N*VW-1:0] analog_in,
  // Value sources
  input wire logic [N*VW-1:0] bus_value_in,
  input wire logic [N-1:0] test_active_in,
  input wire logic [N*VW-1:0] test_value_in,
  // Persistent store restore
  input wire logic [N-1:0] stored_ovr_in,
  input wire logic [N*VW-1:0] stored_value_in,
  // Keys per point: plus, centre, minus (pins)
  input wire logic [N-1:0] key_plus_in,
  input wire logic [N-1:0] key_mid_in,
  input wire logic [N-1:0] key_minus_in,
  // Lamps
  output logic module_lamp_out,
  output logic [N-1:0] point_lamp_out,
  output logic [N*2-1:0] point_colour_out,
  output logic [N-1:0] ovr_lamp_out,
  output logic [N-1:0] error_out,
  // Outputs and reports
  output logic [N*VW-1:0] out_value_out,
  output logic [N-1:0] process_value_field_out,
  output logic [N-1:0] status_flag_field_out,
  output logic ovr_event_out,
  output logic store_we_out,
  output logic [N-1:0] store_ovr_out,
  output logic [N*VW-1:0] store_value_out,
  output logic save_req_out
);
  localparam int VMAX = (1 << VW) - 1;

  typedef struct packed {
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic key_prev;
    logic restored;
    logic [lov_pkg::LOV_CNT_W-1:0] flash_cnt;
    logic flash;
    logic [N-1:0] ovr;
    logic [N*VW-1:0] ovr_val;
    logic [N*VW-1:0] last_out;
    logic [N*VW-1:0] outv;
    logic [N-1:0] err;
    logic [N*lov_pkg::LOV_CNT_W-1:0] err_cnt;
    logic [VW-1:0] pwm;
    logic module_lamp;
    logic [N-1:0] lamp;
    logic [N*2-1:0] colour;
    logic [N-1:0] pv;
    logic evt;
    logic we;
    logic save;
  } lov_st_t;
  lov_st_t st;
  lov_st_t next_st;

  logic [N-1:0] step_up;
  logic [N-1:0] step_dn;
  logic [N-1:0] mid_hold;
  logic [N-1:0] plus_lvl;
  logic [N-1:0] minus_lvl;
  logic [N-1:0] contact_s1;
  logic [N-1:0] contact_s2;
  logic hw_fault_s1;
  logic hw_fault_in_q;
  localparam int LOV_CNT_W = lov_pkg::LOV_CNT_W;

  initial begin
    if (N < 1 || VW < 1 || VW > 8 || FLASH_CYC < 1 || ERR_CYC < 1)
      $error("lov_panel: unsupported parameters");
  end

  // Output-type decode, used in several places
  function automatic logic is_output(input logic [2:0] k);
    is_output = k == lov_pkg::LOV_FN_BIN_OUT || k == lov_pkg::LOV_FN_ANA_OUT ||
                k == lov_pkg::LOV_FN_MULTI_OUT;
  endfunction

  // ==========================================================
  // Key conditioning
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_keys
      lov_key #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .DELAY_CYC(DELAY_CYC),
                .REPEAT_CYC(REPEAT_CYC), .HOLD_CYC(HOLD_CYC)) u_plus (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .key_in(key_plus_in[g]),
        .step_out(step_up[g]), .hold_out(), .level_out(plus_lvl[g]));
      lov_key #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .DELAY_CYC(DELAY_CYC),
                .REPEAT_CYC(REPEAT_CYC), .HOLD_CYC(HOLD_CYC)) u_minus (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .key_in(key_minus_in[g]),
        .step_out(step_dn[g]), .hold_out(), .level_out(minus_lvl[g]));
      lov_key #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .DELAY_CYC(DELAY_CYC),
                .REPEAT_CYC(REPEAT_CYC), .HOLD_CYC(HOLD_CYC)) u_mid (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .key_in(key_mid_in[g]),
        .step_out(), .hold_out(mid_hold[g]), .level_out());
    end
  endgenerate

  // Contacts come from the field, so synchronise them
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      contact_s1 <= '0;
      contact_s2 <= '0;
    end else begin
      contact_s1 <= contact_in;
      contact_s2 <= contact_s1;
    end
  end

  // ==========================================================
  // Main next-state logic
  always_comb begin
    logic healthy;
    logic key_ok;
    logic any_group;
    logic [2:0] kind;
    logic [VW-1:0] v;
    logic [VW-1:0] src;
    logic [VW-1:0] lvl;
    logic multi_taken;
    logic [lov_pkg::LOV_CNT_W-1:0] ec;
    healthy = 1'b0;
    key_ok = 1'b0;
    any_group = 1'b0;
    kind = '0;
    v = '0;
    src = '0;
    lvl = '0;
    multi_taken = 1'b0;
    ec = '0;
    next_st = st;
    next_st.sync_a = {hw_fault_in, parked_in, supply_ok_in};
    next_st.sync_b = st.sync_a;
    next_st.sync_a[2] = addr_key_in;
    next_st.sync_b[2] = st.sync_a[2];
    next_st.evt = 1'b0;
    next_st.we = 1'b0;
    next_st.save = 1'b0;
    next_st.pwm = st.pwm + 1'b1;
    // Fault pin shares no stage with the address key; use supply_ok as the second key gate
    key_ok = st.sync_b[2] && st.sync_b[0]; // R8 R21
    healthy = st.sync_b[0] && !st.sync_b[1] && !hw_fault_in_q;
    next_st.module_lamp = healthy && key_ok; // R1 R2
    next_st.key_prev = st.sync_b[2];
    // Key swivelled out: ask master to save in the same cycle the loads drop
    if (st.key_prev && !st.sync_b[2]) begin
      next_st.save = 1'b1; // R22
    end
    if (st.flash_cnt == LOV_CNT_W'(FLASH_CYC - 1)) begin
      next_st.flash_cnt = '0;
      next_st.flash = !st.flash;
    end else begin
      next_st.flash_cnt = st.flash_cnt + 1'b1;
    end
    if (!st.restored && key_ok) begin
      next_st.restored = 1'b1;
      next_st.ovr = stored_ovr_in & ~ovr_disable_in; // R11
      next_st.ovr_val = stored_value_in;
    end
    for (int i = 0; i < N; i++) begin
      kind = fn_kind_in[i*3 +: 3];
      ec = st.err_cnt[i*LOV_CNT_W +: LOV_CNT_W];
      if (ec != '0) begin
        next_st.err_cnt[i*LOV_CNT_W +: LOV_CNT_W] = ec - 1'b1;
      end else begin
        next_st.err[i] = 1'b0;
      end
      if (key_ok && st.restored) begin
        if (mid_hold[i]) begin
          if (!is_output(kind) || ovr_disable_in[i]) begin
            next_st.err[i] = 1'b1; // R7 R12
            next_st.err_cnt[i*LOV_CNT_W +: LOV_CNT_W] = LOV_CNT_W'(ERR_CYC);
          end else begin
            next_st.ovr[i] = !st.ovr[i]; // R14
            next_st.ovr_val[i*VW +: VW] = st.last_out[i*VW +: VW]; // R9
            next_st.evt = 1'b1;
            next_st.we = 1'b1;
          end
        end else if (step_up[i] || step_dn[i]) begin
          if (!st.ovr[i] || !is_output(kind)) begin
            next_st.err[i] = 1'b1; // R17
            next_st.err_cnt[i*LOV_CNT_W +: LOV_CNT_W] = LOV_CNT_W'(ERR_CYC);
          end else begin
            v = st.ovr_val[i*VW +: VW];
            if (kind == lov_pkg::LOV_FN_BIN_OUT) begin
              v = step_up[i] ? VW'(1) : '0; // R15
            end else if (step_up[i] && v != VW'(VMAX)) begin
              v = v + 1'b1; // R15 R16
            end else if (step_dn[i] && v != '0) begin
              v = v - 1'b1; // R16
            end
            next_st.ovr_val[i*VW +: VW] = v;
            next_st.evt = 1'b1; // R11
            next_st.we = 1'b1;
          end
        end
      end
      if (ovr_disable_in[i]) begin
        next_st.ovr[i] = 1'b0; // R12
      end
      // Source selection; with the key out every load is off
      if (next_st.ovr[i]) begin
        src = next_st.ovr_val[i*VW +: VW]; // R20
      end else if (test_active_in[i]) begin
        src = test_value_in[i*VW +: VW]; // R20
      end else begin
        src = bus_value_in[i*VW +: VW]; // R10 R20
      end
      if (!key_ok || !is_output(kind)) begin
        src = '0; // R21 R22
      end
      if (kind == lov_pkg::LOV_FN_BIN_OUT) begin
        src = VW'(src != '0);
      end
      // Only the lowest active multistate point may drive
      if (kind == lov_pkg::LOV_FN_MULTI_OUT) begin
        src = VW'(src != '0 && !multi_taken); // R13
        multi_taken = multi_taken | (src != '0);
      end
      next_st.outv[i*VW +: VW] = src;
      if (is_output(kind)) begin
        next_st.last_out[i*VW +: VW] = src;
      end
      // Closed contact reads 1 in both types; polarity only moves the lamp
      next_st.pv[i] = contact_s2[i]; // R6
      // Lamps
      lvl = kind == lov_pkg::LOV_FN_ANA_IN ? analog_in[i*VW +: VW] : src;
      unique case (kind)
        lov_pkg::LOV_FN_BIN_IN: next_st.lamp[i] = contact_s2[i] ^ inverse_in[i]; // R3
        lov_pkg::LOV_FN_BIN_OUT: next_st.lamp[i] = src[0]; // R3
        lov_pkg::LOV_FN_MULTI_OUT: next_st.lamp[i] = src[0];
        lov_pkg::LOV_FN_TEMP_IN: next_st.lamp[i] = 1'b0; // R4
        default: next_st.lamp[i] = lvl > st.pwm; // R4
      endcase
      if (group_in[i] && next_st.ovr[i]) begin
        any_group = 1'b1;
      end
      if (!key_ok) begin
        next_st.lamp[i] = 1'b0;
      end
      if (!tricolour_in[i]) begin
        next_st.colour[i*2 +: 2] = lov_pkg::LOV_COL_GREEN;
      end else if (alarm_in[i]) begin
        next_st.colour[i*2 +: 2] = lov_pkg::LOV_COL_RED; // R5
      end else if (service_in[i]) begin
        next_st.colour[i*2 +: 2] = lov_pkg::LOV_COL_YELLOW; // R5
      end else begin
        next_st.colour[i*2 +: 2] = lov_pkg::LOV_COL_GREEN; // R5
      end
    end
    // Multistage group under override: all its lamps flash together
    for (int i = 0; i < N; i++) begin
      if (any_group && group_in[i] && key_ok) begin
        next_st.lamp[i] = st.flash; // R19
      end
    end
  end

  // Fault pin synchroniser kept apart from the packed state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hw_fault_s1 <= 1'b0;
      hw_fault_in_q <= 1'b0;
    end else begin
      hw_fault_s1 <= hw_fault_in;
      hw_fault_in_q <= hw_fault_s1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign module_lamp_out = st.module_lamp;
  assign point_lamp_out = st.lamp;
  assign point_colour_out = st.colour;
  assign ovr_lamp_out = st.ovr; // R18
  assign error_out = st.err;
  assign out_value_out = st.outv;
  assign process_value_field_out = st.pv;
  assign status_flag_field_out = st.ovr; // R11
  assign ovr_event_out = st.evt;
  assign store_we_out = st.we;
  assign store_ovr_out = st.ovr;
  assign store_value_out = st.ovr_val;
  assign save_req_out = st.save;
endmodule
